// >>> core/tcs_pkg.sv
// Package for the transmit control and status register block.
// Assumes a 100 MHz aclk and a 32-bit AXI4-Lite register bus.
package tcs_pkg;
  // Register index 3, byte address four times the index.
  localparam logic [7:0] TCS_REG_INDEX = 8'h03;
  localparam logic [7:0] TCS_REG_ADDR = 8'h0c;
  // Side-band event register of our own choosing.
  localparam logic [7:0] TCS_EVT_ADDR = 8'h10;
  localparam int TCS_BIT_IRQ_REQ = 15;
  localparam int TCS_BIT_LATE_SEL = 14;
  localparam int TCS_BIT_FCS_SUP = 13;
  localparam int TCS_BIT_DEF_OFF = 12;
  localparam int TCS_BIT_DEF_TMO = 10;
  localparam int TCS_BIT_WAITED = 9;
  localparam int TCS_BIT_NO_CRS = 8;
  localparam int TCS_BIT_CRS_LOST = 7;
  localparam int TCS_BIT_EXC_COL = 6;
  localparam int TCS_BIT_LATE_COL = 5;
  localparam int TCS_BIT_MON_BAD = 3;
  localparam int TCS_BIT_UNDERRUN = 2;
  localparam int TCS_BIT_LEN_MIS = 1;
  localparam int TCS_BIT_SENT_OK = 0;
  localparam logic [15:0] TCS_RESET_VAL = 16'h0101;
  localparam logic [15:0] TCS_CFG_MASK = 16'hf000;
  localparam logic [15:0] TCS_STAT_MASK = 16'h07ef;
  localparam logic [15:0] TCS_START_CLR = 16'h04c2;
  localparam logic [15:0] TCS_WB_CLR = 16'h0220;
  localparam logic [4:0] TCS_MAX_COLL = 5'h10;
  localparam int TCS_CLK_MHZ = 100;
  localparam int TCS_DEFER_US = 3200;
  localparam int TCS_SLOT_NS = 51200;
  localparam int TCS_DEFER_CYC = TCS_DEFER_US * TCS_CLK_MHZ;
  localparam int TCS_SLOT_CYC = TCS_SLOT_NS * TCS_CLK_MHZ / 1000;
  localparam logic [1:0] TCS_RESP_OKAY = 2'b00;
  localparam logic [1:0] TCS_RESP_SLVERR = 2'b10;
endpackage : tcs_pkg

// >>> core/tcs_reg.sv
// Transmit control and status register with engine-side event inputs.
// Assumes the transmit engine pulses its event inputs for one cycle each.
//
// Functional notes
// - Transmission start loads config bits 15..12.
// - Transmit end sets status bits when true.
// - Completion writes status plus collision count back.
// - After write-back, clear bits 9 and 5.
// - Next start clears 10,7,6,1; sets 8.
// - Hardware reset sets bits 8,0; clears 1.
// - Software reset leaves register untouched.
// - Bits 15..12 writable; 11 and 4 zero.
// - Descriptor interrupt request raises interrupt flag.
// - Late-window select picks collision timer start.
// - FCS suppress omits the four-byte FCS.
// - Deferral-timer-off disables the deferral timer.
// - Deferring 3.2 ms sets timeout and aborts.
// - Sixteen collisions set flag and abort.
// - Collision after slot time sets late flag.
// - Carrier-never-seen set at start, cleared on carrier in frame.
// - Length mismatch sets flag and aborts.
//
// Local design decision: the AXI4-Lite register port.
`timescale 1ns/1ps
module tcs_reg #(
  parameter int DEFER_CYC = tcs_pkg::TCS_DEFER_CYC
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic soft_reset,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic tx_start,
  input wire logic [15:0] descriptor_config_word,
  input wire logic preamble_start,
  input wire logic sfd_done,
  input wire logic deferring,
  input wire logic carrier_sense,
  input wire logic collision,
  input wire logic tx_end,
  input wire logic mon_bad,
  input wire logic underrun,
  input wire logic length_mismatch,
  input wire logic status_written,
  output logic descriptor_irq_set,
  output logic tx_abort,
  output logic fcs_append,
  output logic status_wb_valid,
  output logic [15:0] descriptor_status_word,
  output logic [4:0] collision_count
);
  import tcs_pkg::*;

  // ****************************************
  // Register bus
  // ****************************************
  logic [15:0] transmit_control_status;
  logic [7:0] aw_addr;
  logic aw_have;
  logic [31:0] w_data;
  logic [3:0] w_strb;
  logic w_have;
  logic in_frame;
  logic [31:0] defer_cnt;
  logic [31:0] slot_cnt;
  logic slot_run;
  logic late_window;

  // Address and data sit in separate holding registers, so the master may
  // offer them in either order. The response goes out only when both are held
  // and no earlier response still waits for bready. That keeps at most one
  // write in flight without any counter.
  wire aw_take = s_axi_awvalid && s_axi_awready;
  wire w_take = s_axi_wvalid && s_axi_wready;
  wire wr_go = aw_have && w_have && !s_axi_bvalid;
  wire wr_hit = aw_addr == TCS_REG_ADDR;
  wire wr_ok = wr_hit || aw_addr == TCS_EVT_ADDR;
  // Only byte lane 1 carries the configuration nibble. A write with that lane
  // off is still answered OKAY, but it changes nothing.
  wire wr_cfg = wr_go && wr_hit && w_strb[1];
  wire ar_take = s_axi_arvalid && s_axi_arready;
  wire rd_hit = s_axi_araddr == TCS_REG_ADDR;
  wire rd_evt = s_axi_araddr == TCS_EVT_ADDR;

  // A second, read-only word at the event address shows tx_abort. Software can
  // poll it for an aborted frame without decoding the status bits.
  wire [31:0] rd_val = rd_hit ? {16'h0000, transmit_control_status} :
                       rd_evt ? {31'h00000000, tx_abort} : 32'h00000000;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_have <= 1'b0;
      w_have <= 1'b0;
      aw_addr <= 8'h00;
      w_data <= 32'h00000000;
      w_strb <= 4'h0;
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= TCS_RESP_OKAY;
    end else begin
      s_axi_awready <= !aw_have && !aw_take;
      s_axi_wready <= !w_have && !w_take;
      if (aw_take) begin
        aw_have <= 1'b1;
        aw_addr <= s_axi_awaddr;
      end
      if (w_take) begin
        w_have <= 1'b1;
        w_data <= s_axi_wdata;
        w_strb <= s_axi_wstrb;
      end
      if (wr_go) begin
        aw_have <= 1'b0;
        w_have <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= wr_ok ? TCS_RESP_OKAY : TCS_RESP_SLVERR;
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // Reads answer one cycle after the address is taken. The word is captured at
  // that edge, so a later engine event cannot change a word already on the bus.
  // Unmapped addresses read as zero with a slave error and have no side effect.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h00000000;
      s_axi_rresp <= TCS_RESP_OKAY;
    end else begin
      s_axi_arready <= !s_axi_rvalid && !ar_take;
      if (ar_take) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata <= rd_val;
        s_axi_rresp <= (rd_hit || rd_evt) ? TCS_RESP_OKAY : TCS_RESP_SLVERR;
      end else if (s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

  // ****************************************
  // Transmit timers
  // ****************************************
  // The soft reset input is deliberately not used by the register below.
  // A software reset must leave every configuration and status bit as it
  // stands; only the hardware reset clears or presets them.
  wire timer_on = !transmit_control_status[TCS_BIT_DEF_OFF];
  wire defer_hit = timer_on && deferring && defer_cnt >= DEFER_CYC - 1;
  wire coll_abort = collision && collision_count == TCS_MAX_COLL - 5'h01;
  wire slot_go = transmit_control_status[TCS_BIT_LATE_SEL] ? preamble_start : sfd_done;
  wire late_hit = collision && late_window;

  // Both counters are cleared at every transmission start, so a window or a
  // deferral count left from an aborted packet never leaks into the next one.
  // The deferral count restarts whenever deferring drops, because only one
  // unbroken deferral period counts as excessive.
  // The slot counter runs on after the window has opened; the window flag
  // then holds until the next start. The counters are 32 bits wide, far more
  // than the slot needs, which keeps the comparisons plain.
  always_ff @(posedge aclk) begin
    if (!aresetn || tx_start) begin
      defer_cnt <= 32'h00000000;
      slot_cnt <= 32'h00000000;
      slot_run <= 1'b0;
      late_window <= 1'b0;
    end else begin
      defer_cnt <= (deferring && timer_on) ? defer_cnt + 32'h00000001 : 32'h00000000;
      if (slot_go) begin
        slot_run <= 1'b1;
        slot_cnt <= 32'h00000000;
      end else if (slot_run) begin
        slot_cnt <= slot_cnt + 32'h00000001;
        if (slot_cnt >= TCS_SLOT_CYC - 1) begin
          late_window <= 1'b1;
        end
      end
    end
  end

  // ****************************************
  // Register and events
  // ****************************************
  // Start value: the configuration comes from the fetched descriptor, the
  // start-cleared status bits drop, and carrier-never-seen is raised again,
  // ready for the carrier monitor of the new frame.
  wire [15:0] start_val = (transmit_control_status & ~TCS_CFG_MASK & ~TCS_START_CLR)
                          | (descriptor_config_word & TCS_CFG_MASK)
                          | (16'h0001 << TCS_BIT_NO_CRS);
  wire crs_seen = in_frame && carrier_sense;

  // Events of the packet, before and during the frame. Bit 1 is also raised on the sixteenth collision,
  // so software sees one abort cause for both kinds of count fault.
  wire [15:0] evt_set = (16'(defer_hit) << TCS_BIT_DEF_TMO)
                      | (16'(deferring && !in_frame) << TCS_BIT_WAITED)
                      | (16'(coll_abort) << TCS_BIT_EXC_COL)
                      | (16'(coll_abort || length_mismatch) << TCS_BIT_LEN_MIS)
                      | (16'(late_hit) << TCS_BIT_LATE_COL)
                      | (16'(underrun) << TCS_BIT_UNDERRUN);

  // Conditions judged once, at the end of the frame. Packet-monitored-bad is
  // held low while the FCS is suppressed, as there is no checksum to judge.
  // Sent-ok needs no abort and no underrun in that same cycle, since an
  // underrun only reaches tx_abort one cycle later.
  wire [15:0] end_set = (16'(in_frame && !carrier_sense) << TCS_BIT_CRS_LOST)
                      | (16'(mon_bad && !transmit_control_status[TCS_BIT_FCS_SUP])
                         << TCS_BIT_MON_BAD)
                      | (16'(!tx_abort && !underrun) << TCS_BIT_SENT_OK);

  // The write-back and carrier clears go first, so a same-cycle event still lands.
  wire [15:0] wb_clr = status_written ? TCS_WB_CLR : 16'h0000;
  wire [15:0] crs_clr = crs_seen ? (16'h0001 << TCS_BIT_NO_CRS) : 16'h0000;
  wire [15:0] evt_add = evt_set & TCS_STAT_MASK;
  wire [15:0] end_add = tx_end ? (end_set & TCS_STAT_MASK) : 16'h0000;
  wire [15:0] next_status = ((transmit_control_status & ~wb_clr & ~crs_clr) | evt_add | end_add)
                            & (TCS_CFG_MASK | TCS_STAT_MASK);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      transmit_control_status <= TCS_RESET_VAL;
    end else if (tx_start) begin
      transmit_control_status <= start_val;
    end else begin
      transmit_control_status <= next_status;
      if (wr_cfg) begin
        transmit_control_status[15:12] <= w_data[15:12];
      end
    end
  end


  // ****************************************
  // Engine outputs
  // ****************************************
  // The interrupt request is a single-cycle pulse per fetch. Software need not
  // alternate the request bit between descriptors, since the pulse carries
  // no memory of earlier packets.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      in_frame <= 1'b0;
      collision_count <= 5'h00;
      tx_abort <= 1'b0;
      descriptor_irq_set <= 1'b0;
      fcs_append <= 1'b1;
      status_wb_valid <= 1'b0;
      descriptor_status_word <= 16'h0000;
    end else begin
      descriptor_irq_set <= tx_start && descriptor_config_word[TCS_BIT_IRQ_REQ];
      fcs_append <= !transmit_control_status[TCS_BIT_FCS_SUP];
      status_wb_valid <= tx_end;
      if (tx_end) begin
        // The collision count rides in the top five bits, over the config bits.
        descriptor_status_word <= {collision_count,
                                   transmit_control_status[10:0] | end_set[10:0]};
      end
      if (tx_start) begin
        in_frame <= 1'b0;
        collision_count <= 5'h00;
        tx_abort <= 1'b0;
      end else begin
        if (preamble_start) begin
          in_frame <= 1'b1;
        end else if (tx_end) begin
          in_frame <= 1'b0;
        end
        // The count stops at sixteen: the abort has been raised by then and
        // further collisions carry no meaning for this packet.
        if (collision && collision_count != TCS_MAX_COLL) begin
          collision_count <= collision_count + 5'h01;
        end
        if (defer_hit || coll_abort || length_mismatch || underrun) begin
          tx_abort <= 1'b1;
        end
      end
    end
  end
endmodule : tcs_reg

// >>> tb/tcs_dma_model.sv
// Descriptor memory model: stores the written-back status word.
// Assumes the block pulses status_wb_valid for one cycle per packet.
`timescale 1ns/1ps
module tcs_dma_model (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic status_wb_valid,
  input wire logic [15:0] descriptor_status_word,
  output logic status_written,
  output logic [15:0] stored_status
);
  // ****************************************
  // Write-back
  // ****************************************
  // The acknowledge comes at the same edge as the store, one cycle after status_wb_valid.
  always_ff @(posedge aclk) begin
    status_written <= aresetn && status_wb_valid;
    if (status_wb_valid) begin
      stored_status <= descriptor_status_word;
    end
  end
endmodule : tcs_dma_model

// >>> tb/tcs_reg_asserts.sv
// Concurrent checks on the transmit control and status register ports.
// Assumes it is bound into tcs_reg and sees only that module's ports.
`timescale 1ns/1ps
module tcs_reg_asserts (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic tx_start,
  input wire logic [15:0] descriptor_config_word,
  input wire logic length_mismatch,
  input wire logic tx_end,
  input wire logic descriptor_irq_set,
  input wire logic tx_abort,
  input wire logic fcs_append,
  input wire logic status_wb_valid,
  input wire logic [4:0] collision_count
);
  // ****************************************
  // Port relations
  // ****************************************
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  a_irq_pulse: assert property (tx_start && descriptor_config_word[15] |=> descriptor_irq_set)
    else $error("descriptor interrupt not raised");
  a_irq_cause: assert property (descriptor_irq_set |-> $past(tx_start) && $past(descriptor_config_word[15]))
    else $error("descriptor interrupt without request");
  a_fcs_follow: assert property (tx_start |-> ##2 fcs_append != $past(descriptor_config_word[13], 2))
    else $error("fcs append does not follow config");
  a_wb_pulse: assert property (tx_end |=> status_wb_valid)
    else $error("no status write-back after end");
  a_wb_cause: assert property (status_wb_valid |-> $past(tx_end))
    else $error("write-back without end");
  a_abort_clear: assert property (tx_start |=> !tx_abort)
    else $error("abort not cleared at start");
  a_len_abort: assert property (length_mismatch && !tx_start |=> tx_abort)
    else $error("length mismatch did not abort");
  a_coll_sat: assert property (collision_count == 5'h10 && !tx_start |=> collision_count == 5'h10)
    else $error("collision count left saturation");
  cover property (descriptor_irq_set);
  cover property (status_wb_valid);
  cover property (collision_count == 5'h10);
endmodule : tcs_reg_asserts

bind tcs_reg tcs_reg_asserts u_chk (.aclk, .aresetn, .tx_start, .descriptor_config_word,
  .length_mismatch, .tx_end, .descriptor_irq_set, .tx_abort, .fcs_append, .status_wb_valid,
  .collision_count);

// >>> tb/tcs_reg_bench.sv
// Self-checking bench for tcs_reg with AXI4-Lite tasks and engine pulses.
// Assumes a short deferral limit of 20 cycles.
`timescale 1ns/1ps
module tcs_reg_bench;
  import tcs_pkg::*;
  // ****************************************
  // Stimulus and checks
  // ****************************************
  logic aclk = 0, aresetn = 0, soft_reset = 0, deferring = 0, crs = 0;
  logic [7:0] ev = 0, awaddr = 0, araddr = 0;
  logic [15:0] cfg = 0;
  logic [31:0] wdata = 0, rdata, v;
  logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
  logic awready, wready, bvalid, arready, rvalid, irq, abort, fcs, wbv, wdone;
  logic [1:0] bresp, rresp, r;
  logic [15:0] dsw, stored;
  logic [4:0] ccnt;
  int err_count = 0;
  int check_count = 0;
  initial begin
    forever #5 aclk = ~aclk;
  end
  tcs_reg #(.DEFER_CYC(20)) DUT (.aclk(aclk), .aresetn(aresetn), .soft_reset(soft_reset),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .tx_start(ev[0]), .descriptor_config_word(cfg), .preamble_start(ev[1]), .sfd_done(ev[2]),
    .deferring(deferring), .carrier_sense(crs), .collision(ev[3]), .tx_end(ev[4]),
    .mon_bad(ev[5]), .underrun(ev[6]), .length_mismatch(ev[7]), .status_written(wdone),
    .descriptor_irq_set(irq), .tx_abort(abort), .fcs_append(fcs), .status_wb_valid(wbv),
    .descriptor_status_word(dsw), .collision_count(ccnt));
  tcs_dma_model u_dma (.aclk(aclk), .aresetn(aresetn), .status_wb_valid(wbv),
    .descriptor_status_word(dsw), .status_written(wdone), .stored_status(stored));
  task automatic give_verdict;
    $display("checks %0d mismatches %0d", check_count, err_count);
    if (err_count == 0 && check_count > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : give_verdict
  task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      err_count++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk
  task automatic rd(input logic [7:0] a);
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do @(posedge aclk); while (!arready);
    arvalid <= 1'b0;
    while (!rvalid) @(posedge aclk);
    v = rdata;
    r = rresp;
    rready <= 1'b0;
  endtask : rd
  task automatic wr(input logic [31:0] d);
    logic ta, tw;
    ta = 0;
    tw = 0;
    @(posedge aclk);
    awaddr <= TCS_REG_ADDR;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (!(ta && tw)) begin
      @(posedge aclk);
      ta = ta | awready;
      tw = tw | wready;
      if (ta) awvalid <= 1'b0;
      if (tw) wvalid <= 1'b0;
    end
    while (!bvalid) @(posedge aclk);
    bready <= 1'b0;
  endtask : wr
  task automatic pulse(input logic [7:0] m, input int n);
    repeat (n) begin
      @(posedge aclk);
      ev <= m;
      @(posedge aclk);
      ev <= 8'h00;
    end
    // Let the last event's results settle before anyone looks at them.
    @(posedge aclk);
  endtask : pulse
  task automatic t_regs;
    rd(TCS_REG_ADDR);
    chk("reset value", v, 32'h0000_0101);
    wr(32'hffff_ffff);
    rd(TCS_REG_ADDR);
    chk("config write", v[15:12], 4'hf);
    chk("status kept", v[11:0], 12'h101);
    chk("fcs off", fcs, 1'b0);
    soft_reset <= 1'b1;
    @(posedge aclk);
    soft_reset <= 1'b0;
    rd(TCS_REG_ADDR);
    chk("soft reset", v, 32'h0000_f101);
    rd(8'h20);
    chk("unmapped", {v[31:2], r}, 32'h2);
  endtask : t_regs
  task automatic t_frame;
    cfg <= 16'ha000;
    pulse(8'h01, 1);
    rd(TCS_REG_ADDR);
    chk("start load", v, 32'h0000_a101);
    pulse(8'h08, 16);
    chk("coll count", ccnt, 5'h10);
    chk("coll abort", abort, 1'b1);
    pulse(8'h10, 1);
    repeat (2) @(posedge aclk);
    chk("wb status", stored & 16'h0042, 16'h0042);
    chk("wb count", stored[15:11], 5'h10);
    cfg <= 16'h0000;
    pulse(8'h01, 1);
    rd(TCS_REG_ADDR);
    chk("start clear", v & 32'h05c2, 32'h0100);
  endtask : t_frame
  task automatic t_defer(input logic [15:0] c, input logic [31:0] exp);
    cfg <= c;
    pulse(8'h01, 1);
    deferring <= 1'b1;
    repeat (25) @(posedge aclk);
    deferring <= 1'b0;
    rd(TCS_REG_ADDR);
    chk("defer flag", v & 32'h0400, exp);
  endtask : t_defer
  task automatic t_carrier;
    cfg <= 16'h4000;
    pulse(8'h01, 1);
    pulse(8'h02, 1);
    crs <= 1'b1;
    pulse(8'h08, 1);
    rd(TCS_REG_ADDR);
    chk("early coll", v & 32'h0120, 32'h0000);
    repeat (5130) @(posedge aclk);
    pulse(8'h08, 1);
    rd(TCS_REG_ADDR);
    chk("late coll", v & 32'h0120, 32'h0020);
  endtask : t_carrier
  initial begin
    repeat (12) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (2) @(posedge aclk);
    t_regs();
    t_frame();
    t_defer(16'h0000, 32'h0400);
    t_defer(16'h1000, 32'h0000);
    t_carrier();
    pulse(8'h80, 1);
    rd(TCS_REG_ADDR);
    chk("len mismatch", v & 32'h0002, 32'h0002);
    pulse(8'h10, 1);
    repeat (3) @(posedge aclk);
    rd(TCS_REG_ADDR);
    chk("wb clear", v & 32'h0220, 32'h0000);
    give_verdict();
  end
  initial begin
    repeat (20000) @(posedge aclk);
    err_count++;
    give_verdict();
  end
endmodule : tcs_reg_bench
